/* field_enc_pkg.sv */
// package for the binary field encoder: constants, modes and carrier structs
// assumes a single 200 MHz clock domain and a synchronous active-high reset
// Overview of operation
// - scale value by ten per decimal place
// - word is six times width bits, signed
// - one byte per six-bit chunk, low bits
// - bit seven of every byte forced high
// - radio: bit eight set on even parity
// - terminal: pattern 01 above each chunk
// - encoded bytes go to port, not log
// - at most 355 bytes per transmission
package field_enc_pkg;
    localparam int unsigned CHUNK_W = 6;
    localparam int unsigned MAX_WIDTH = 4;
    localparam int unsigned WIDTH_W = 3;
    localparam int unsigned DEC_W = 4;
    localparam int unsigned VALUE_W = 32;
    localparam int unsigned ACC_W = 64;
    localparam int unsigned WORD_W = CHUNK_W * MAX_WIDTH;
    localparam int unsigned MAX_BYTES = 355;
    localparam int unsigned CNT_W = 9;
    localparam logic [CNT_W-1:0] MAX_BYTES_C = 9'h163;
    localparam logic [1:0] TERM_TOP = 2'h1;
    localparam logic [CNT_W-1:0] CNT_RESET = 9'h000;

    typedef enum logic {DEST_TERMINAL, DEST_RADIO} dest_e;
    typedef enum logic [1:0] {ST_IDLE, ST_SCALE, ST_EMIT} state_e;

    typedef struct packed {
        logic signed [VALUE_W-1:0] value;
        logic [DEC_W-1:0] decimals;
        logic [WIDTH_W-1:0] width;
    } field_s;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } byte_s;
endpackage

/* byte_skid.sv */
// two-entry buffer between encoder and serial port
// assumes both sides on clk_i; ce_i freezes all state
`timescale 1ns/100ps
module byte_skid
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire field_enc_pkg::byte_s in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output field_enc_pkg::byte_s out_data_o
);
    typedef struct packed {
        field_enc_pkg::byte_s head;
        field_enc_pkg::byte_s tail;
        logic head_valid;
        logic tail_valid;
    } skid_s;

    skid_s st_r;
    skid_s st_nxt;
    logic push;
    logic pop;

    // both sides see only flops: the head feeds the outputs, the tail frees ready
    assign in_ready_o = !st_r.tail_valid;
    assign out_valid_o = st_r.head_valid;
    assign out_data_o = st_r.head;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb
    begin
        st_nxt = st_r;
        if (pop)
        begin
            st_nxt.head = st_r.tail;
            st_nxt.head_valid = st_r.tail_valid;
            st_nxt.tail_valid = 1'b0;
        end
        if (push)
        begin
            if (!st_nxt.head_valid)
            begin
                st_nxt.head = in_data_i;
                st_nxt.head_valid = 1'b1;
            end
            else
            begin
                st_nxt.tail = in_data_i;
                st_nxt.tail_valid = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            st_r <= '0;
        end
        else if (ce_i)
        begin
            st_r <= st_nxt;
        end
    end
endmodule

/* field_encoder.sv */
// binary field encoder: scales a value, splits it into printable six-bit bytes
// assumes the formatter holds field_i stable while field_valid_i and not ready
`timescale 1ns/100ps
module field_encoder
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic field_valid_i,
    output logic field_ready_o,
    input wire field_enc_pkg::field_s field_i,
    input wire field_enc_pkg::dest_e dest_i,
    input wire logic xmit_start_i,
    output logic byte_valid_o,
    input wire logic byte_ready_i,
    output logic [7:0] byte_data_o,
    output logic byte_last_o,
    output logic log_write_o,
    output logic overflow_o,
    output logic [field_enc_pkg::CNT_W-1:0] byte_count_o
);
    typedef struct packed {
        field_enc_pkg::state_e state;
        logic signed [field_enc_pkg::ACC_W-1:0] acc;
        logic [field_enc_pkg::DEC_W-1:0] dec_left;
        logic [field_enc_pkg::WIDTH_W-1:0] chunks_left;
        field_enc_pkg::dest_e dest;
        logic [field_enc_pkg::CNT_W-1:0] sent;
        logic overflow;
        logic field_ready;
        logic out_valid;
        field_enc_pkg::byte_s out_byte;
        logic log_write;
    } enc_s;

    enc_s st_r;
    enc_s st_nxt;
    logic buf_in_ready;
    logic buf_out_valid;
    field_enc_pkg::byte_s buf_out;
    logic [field_enc_pkg::WORD_W-1:0] word;
    logic [5:0] chunk;
    logic [6:0] low7;
    logic [7:0] enc_byte;
    logic [field_enc_pkg::WIDTH_W-1:0] width_clamped;
    logic cap_hit;
    logic last_chunk;

    function automatic logic signed [field_enc_pkg::ACC_W-1:0] acc_sx(
        input logic signed [field_enc_pkg::VALUE_W-1:0] v);
        acc_sx = {{(field_enc_pkg::ACC_W-field_enc_pkg::VALUE_W){v[field_enc_pkg::VALUE_W-1]}}, v};
    endfunction

    // word sign is the top bit of width*6 bits: two's complement truncation
    assign word = st_r.acc[field_enc_pkg::WORD_W-1:0];
    assign low7 = {1'b1, chunk};
    assign last_chunk = (st_r.chunks_left == 3'h1);
    // a start opens a new count, so the cap never bites on that edge
    assign cap_hit = (st_r.sent >= field_enc_pkg::MAX_BYTES_C) && !xmit_start_i;

    // chunk select walks the word down from its most significant six bits
    always_comb
    begin
        case (st_r.chunks_left)
            3'h4:
            begin
                chunk = word[3*field_enc_pkg::CHUNK_W +: field_enc_pkg::CHUNK_W];
            end
            3'h3:
            begin
                chunk = word[2*field_enc_pkg::CHUNK_W +: field_enc_pkg::CHUNK_W];
            end
            3'h2:
            begin
                chunk = word[field_enc_pkg::CHUNK_W +: field_enc_pkg::CHUNK_W];
            end
            3'h1:
            begin
                chunk = word[0 +: field_enc_pkg::CHUNK_W];
            end
            default:
            begin
                chunk = word[0 +: field_enc_pkg::CHUNK_W];
            end
        endcase
    end

    always_comb
    begin
        case (st_r.dest)
            field_enc_pkg::DEST_RADIO:
            begin
                // top bit is high when the lower seven bits hold an even count of ones
                enc_byte = {~(^low7), low7};
            end
            field_enc_pkg::DEST_TERMINAL:
            begin
                enc_byte = {field_enc_pkg::TERM_TOP, chunk};
            end
            default:
            begin
                enc_byte = {field_enc_pkg::TERM_TOP, chunk};
            end
        endcase
    end

    always_comb
    begin
        if (field_i.width > 3'(field_enc_pkg::MAX_WIDTH))
        begin
            width_clamped = 3'(field_enc_pkg::MAX_WIDTH);
        end
        else
        begin
            width_clamped = field_i.width;
        end
    end

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.field_ready = 1'b0;
        st_nxt.log_write = 1'b0;
        if (st_r.out_valid && buf_in_ready)
        begin
            st_nxt.out_valid = 1'b0;
        end
        if (xmit_start_i)
        begin
            st_nxt.sent = field_enc_pkg::CNT_RESET;
            st_nxt.overflow = 1'b0;
        end
        case (st_r.state)
            field_enc_pkg::ST_IDLE:
            begin
                if (field_valid_i && !st_r.field_ready)
                begin
                    st_nxt.acc = acc_sx(field_i.value);
                    st_nxt.dec_left = field_i.decimals;
                    st_nxt.chunks_left = width_clamped;
                    st_nxt.dest = dest_i;
                    st_nxt.field_ready = 1'b1;
                    st_nxt.state = field_enc_pkg::ST_SCALE;
                end
            end
            field_enc_pkg::ST_SCALE:
            begin
                if (st_r.dec_left != '0)
                begin
                    st_nxt.acc = st_r.acc * 64'sd10;
                    st_nxt.dec_left = st_r.dec_left - 4'h1;
                end
                else if (st_r.chunks_left == '0)
                begin
                    st_nxt.state = field_enc_pkg::ST_IDLE;
                end
                else
                begin
                    st_nxt.state = field_enc_pkg::ST_EMIT;
                end
            end
            field_enc_pkg::ST_EMIT:
            begin
                if (!st_r.out_valid || buf_in_ready)
                begin
                    if (cap_hit)
                    begin
                        // the chunk is still consumed so the field ends in step
                        st_nxt.overflow = 1'b1;
                    end
                    else
                    begin
                        st_nxt.out_valid = 1'b1;
                        st_nxt.out_byte.data = enc_byte;
                        st_nxt.out_byte.last = last_chunk;
                        st_nxt.sent = st_nxt.sent + 9'h1;
                    end
                    st_nxt.chunks_left = st_r.chunks_left - 3'h1;
                    if (last_chunk)
                    begin
                        st_nxt.state = field_enc_pkg::ST_IDLE;
                    end
                end
            end
            default:
            begin
                st_nxt.state = field_enc_pkg::ST_IDLE;
            end
        endcase
    end

    // the buffer's head register drives the byte outputs directly
    byte_skid u_skid
    (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .in_valid_i(st_r.out_valid),
        .in_ready_o(buf_in_ready),
        .in_data_i(st_r.out_byte),
        .out_valid_o(buf_out_valid),
        .out_ready_i(byte_ready_i),
        .out_data_o(buf_out)
    );

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            st_r <= '0;
        end
        else if (ce_i)
        begin
            st_r <= st_nxt;
        end
    end

    assign field_ready_o = st_r.field_ready;
    assign byte_valid_o = buf_out_valid;
    assign byte_data_o = buf_out.data;
    assign byte_last_o = buf_out.last;
    assign log_write_o = st_r.log_write;
    assign overflow_o = st_r.overflow;
    assign byte_count_o = st_r.sent;
endmodule

/* field_enc_checker.sv */
// port checker for the field encoder
// assumes one clock domain and the synchronous high reset
`timescale 1ns/100ps
module field_enc_checker
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic xmit_start_i,
    input wire logic byte_valid_o,
    input wire logic byte_ready_i,
    input wire logic [7:0] byte_data_o,
    input wire logic log_write_o,
    input wire logic overflow_o,
    input wire logic field_ready_o,
    input wire logic [field_enc_pkg::CNT_W-1:0] byte_count_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    sequence stalled;
        byte_valid_o && !byte_ready_i;
    endsequence
    no_log_a: assert property (!log_write_o) else $error("log write seen");
    bit_seven_a: assert property (byte_valid_o |-> byte_data_o[6]) else $error("bit 7 low");
    stall_hold_a: assert property (stalled |=> byte_valid_o && $stable(byte_data_o))
        else $error("byte lost in stall");
    count_cap_a: assert property (byte_count_o <= field_enc_pkg::MAX_BYTES_C)
        else $error("count above cap");
    over_hold_a: assert property (overflow_o && !xmit_start_i |=> overflow_o)
        else $error("overflow dropped");
    over_cap_a: assert property ($rose(overflow_o) |-> byte_count_o == field_enc_pkg::MAX_BYTES_C)
        else $error("overflow early");
    start_clear_a: assert property (xmit_start_i |=> byte_count_o <= 9'h001 && !overflow_o)
        else $error("start did not clear");
    count_step_a: assert property (!xmit_start_i |=> byte_count_o - $past(byte_count_o) <= 9'h001)
        else $error("count jumped");
    ready_pulse_a: assert property (field_ready_o |=> !field_ready_o) else $error("ready long");
endmodule
bind field_encoder field_enc_checker u_field_enc_checker (.clk_i(clk_i), .reset_i(reset_i),
    .xmit_start_i(xmit_start_i), .byte_valid_o(byte_valid_o), .byte_ready_i(byte_ready_i),
    .byte_data_o(byte_data_o), .log_write_o(log_write_o), .overflow_o(overflow_o),
    .field_ready_o(field_ready_o), .byte_count_o(byte_count_o));

/* port_sink.sv */
// serial port model that takes encoded bytes
// assumes a valid and ready handshake on clk_i
`timescale 1ns/100ps
module port_sink
(
    input wire logic clk_i,
    input wire logic slow_i,
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_data_i,
    output logic byte_ready_o
);
    logic [7:0] got[$];
    logic ready_r = 1'b0;

    assign byte_ready_o = ready_r;
    always @(posedge clk_i)
    begin
        if (byte_valid_i && byte_ready_o)
            got.push_back(byte_data_i);
    end
    // slow mode stalls every other cycle
    always @(negedge clk_i)
    begin
        ready_r <= slow_i ? ~ready_r : 1'b1;
    end
endmodule

/* testbench.sv */
// self-checking bench for the field encoder
// assumes the port model and checker are compiled first
`timescale 1ns/100ps
module testbench;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic field_valid_i = 1'b0;
    logic xmit_start_i = 1'b0;
    logic slow = 1'b0;
    logic byte_ready_i;
    logic byte_valid_o;
    logic field_ready_o;
    logic overflow_o;
    logic byte_last_o;
    logic [7:0] byte_data_o;
    logic [field_enc_pkg::CNT_W-1:0] byte_count_o;
    field_enc_pkg::field_s field_i = '0;
    field_enc_pkg::dest_e dest_i = field_enc_pkg::DEST_TERMINAL;
    logic [8:0] exp[$];
    logic last_q[$];
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    always #2.5 clk_i = ~clk_i;
    field_encoder u_field_encoder (.clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1),
        .field_valid_i(field_valid_i), .field_ready_o(field_ready_o), .field_i(field_i),
        .dest_i(dest_i), .xmit_start_i(xmit_start_i), .byte_valid_o(byte_valid_o),
        .byte_ready_i(byte_ready_i), .byte_data_o(byte_data_o), .byte_last_o(byte_last_o),
        .log_write_o(), .overflow_o(overflow_o), .byte_count_o(byte_count_o));
    port_sink u_port_sink (.clk_i(clk_i), .slow_i(slow), .byte_valid_i(byte_valid_o),
        .byte_data_i(byte_data_o), .byte_ready_o(byte_ready_i));
    task end_of_test;
        if (n_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task check(input logic [8:0] got, input logic [8:0] want);
        check_count++;
        if (got !== want)
        begin
            n_errors++;
            $display("[ERR] %0t got %h want %h", $time, got, want);
        end
    endtask
    task send(input logic signed [31:0] v, input logic [3:0] d, input logic [2:0] w,
        input logic radio);
        longint s;
        logic [23:0] word;
        logic [5:0] c;
        int n;
        s = v;
        repeat (d) s = s * 10;
        word = s[23:0];
        n = (w > 3'(field_enc_pkg::MAX_WIDTH)) ? int'(field_enc_pkg::MAX_WIDTH) : int'(w);
        for (int i = n - 1; i >= 0; i--)
        begin
            c = word[i*6 +: 6];
            exp.push_back({i == 0, radio ? {~^{1'b1, c}, 1'b1, c} : {2'b01, c}});
        end
        @(negedge clk_i);
        field_i = '{value: v, decimals: d, width: w};
        dest_i = field_enc_pkg::dest_e'(radio);
        field_valid_i = 1'b1;
        @(negedge clk_i);
        while (field_ready_o !== 1'b1)
            @(negedge clk_i);
        field_valid_i = 1'b0;
    endtask
    task drain;
        int k;
        k = 0;
        while (u_port_sink.got.size() < exp.size() && k < 1000)
        begin
            @(negedge clk_i);
            k++;
        end
        repeat (6) @(negedge clk_i);
        check(9'(u_port_sink.got.size()), 9'(exp.size()));
        foreach (exp[i])
            check({last_q[i], u_port_sink.got[i]}, exp[i]);
        exp.delete();
        last_q.delete();
        u_port_sink.got.delete();
    endtask
    task restart;
        @(negedge clk_i);
        xmit_start_i = 1'b1;
        @(negedge clk_i);
        xmit_start_i = 1'b0;
        @(negedge clk_i);
    endtask
    always @(posedge clk_i)
    begin
        if (byte_valid_o && byte_ready_i)
            last_q.push_back(byte_last_o);
    end
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            $display("[ERR] %0t timeout", $time);
            end_of_test;
        end
    end
    initial
    begin
        repeat (10) @(negedge clk_i);
        reset_i = 1'b0;
        send(32'sd2362, 4'h0, 3'h3, 1'b0);
        send(32'sd2362, 4'h0, 3'h7, 1'b0);
        send(32'sd5, 4'h0, 3'h0, 1'b1);
        drain;
        slow = 1'b1;
        send(-32'sd7, 4'hf, 3'h4, 1'b1);
        send(32'sd236, 4'h1, 3'h1, 1'b1);
        send(-32'sd45, 4'h2, 3'h2, 1'b0);
        drain;
        restart;
        for (int i = 0; i < 90; i++)
            send(32'(i * 4099 - 99999), 4'h0, 3'h4, 1'b1);
        while (exp.size() > 355)
            void'(exp.pop_back());
        drain;
        check({8'h00, overflow_o}, 9'h001);
        check(byte_count_o, 9'h163);
        restart;
        check({overflow_o, byte_count_o[7:0]}, 9'h000);
        check(byte_count_o, 9'h000);
        end_of_test;
    end
endmodule
